// File: dee_ctrl.v
// Overview of operation
// - Array access works in normal operation through plain registers, no special mode.
// - Each write is one byte: erase the byte, then program the new value.
// - Address register bits 6..0 select one of 128 bytes.
// - Address register bit 7 is unused and always reads zero.
// - Data register holds write data and receives fetched read data.
// - Data register is a full eight-bit field.
// - Control bit 3 powers the array when 1, switches it off when 0.
// - Control bit 5 allows writes; when 0 no write cycle happens.
// - Control bit 6 set to 1, with bits 5 and 3 also set, starts erase-then-program on the addressed byte.
// - Control bit 7 set to 1 with bit 6 at 0 fetches the addressed byte; 0 does nothing.
// - Busy bit 4 and write trigger read 1 during a write, cleared at end.
`include "dee_defs.vh"
`default_nettype none
module dee_ctrl #(
	parameter DEPTH = 128,
	parameter AW = 7,
	parameter ERASE_CYC = `DEE_ERASE_CYC,
	parameter PROG_CYC = `DEE_PROG_CYC
) (
	input wire mclk,
	input wire nrst,
	input wire [2:0] regAddr,
	input wire [7:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdata,
	output reg irq
);
	localparam TW = 12;
	localparam ST_IDLE = 2'h0;
	localparam ST_ERASE = 2'h1;
	localparam ST_PROG = 2'h2;
	localparam ST_READ = 2'h3;

	reg rstMeta_r;
	reg rstSync_r;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg readTrig_r;
	reg writeTrig_r;
	reg writeAllow_r;
	reg busy_r;
	reg powerOn_r;
	reg [AW-1:0] byteAddr_r;
	reg [7:0] byteData_r;
	reg [2:0] irqStat_r;
	reg [2:0] irqEn_r;
	reg timerLoad;
	reg [TW-1:0] timerCount;
	wire timerDone;
	wire [7:0] arrayData;

	function [7:0] ctrlValue;
		input rdT;
		input wrT;
		input wa;
		input bsy;
		input pw;
		begin
			ctrlValue = {rdT, wrT, wa, bsy, pw, 3'h0};
		end
	endfunction

	wire wrCtrl = regWr && (regAddr == `DEE_ADDR_CTRL);
	wire idle = (state_r == ST_IDLE);
	// Triggers are taken only when idle; a trigger during a busy cycle is ignored.
	wire startWrite = wrCtrl && idle && regWdata[`DEE_CTRL_WRITE];
	wire startRead = wrCtrl && idle && regWdata[`DEE_CTRL_READ] && !regWdata[`DEE_CTRL_WRITE];
	wire writeOk = regWdata[`DEE_CTRL_WALLOW] && regWdata[`DEE_CTRL_PWR];
	wire writeGo = startWrite && writeOk;
	wire writeRej = startWrite && !writeOk;

	always @* begin
		state_nxt = state_r;
		timerLoad = 1'b0;
		timerCount = {TW{1'b0}};
		case (state_r)
			ST_IDLE: begin
				if (writeGo) begin
					state_nxt = ST_ERASE;
					timerLoad = 1'b1;
					timerCount = ERASE_CYC[TW-1:0];
				end else if (startRead) begin
					state_nxt = ST_READ;
				end
			end
			ST_ERASE: begin
				if (timerDone) begin
					state_nxt = ST_PROG;
					timerLoad = 1'b1;
					timerCount = PROG_CYC[TW-1:0];
				end
			end
			ST_PROG: begin
				if (timerDone) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_READ: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	wire eraseEn = (state_r == ST_ERASE) && timerDone;
	wire progEn = (state_r == ST_PROG) && timerDone;
	wire readDone = (state_r == ST_READ);

	always @(posedge mclk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			state_r <= ST_IDLE;
			readTrig_r <= 1'b0;
			writeTrig_r <= 1'b0;
			writeAllow_r <= 1'b0;
			busy_r <= 1'b0;
			powerOn_r <= 1'b0;
			byteAddr_r <= {AW{1'b0}};
			byteData_r <= `DEE_BDATA_RST;
			irqStat_r <= 3'h0;
			irqEn_r <= 3'h0;
			regRdata <= 8'h00;
			irq <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (wrCtrl) begin
				writeAllow_r <= regWdata[`DEE_CTRL_WALLOW];
				powerOn_r <= regWdata[`DEE_CTRL_PWR];
			end
			// Triggers and busy are owned by hardware once a cycle starts.
			if (writeGo) begin
				writeTrig_r <= 1'b1;
				busy_r <= 1'b1;
			end else if (progEn) begin
				writeTrig_r <= 1'b0;
				busy_r <= 1'b0;
			end
			if (startRead) begin
				readTrig_r <= 1'b1;
			end else if (readDone) begin
				readTrig_r <= 1'b0;
			end
			if (regWr && regAddr == `DEE_ADDR_BADDR && idle) begin
				byteAddr_r <= regWdata[AW-1:0];
			end
			if (readDone) begin
				byteData_r <= arrayData;
			end else if (regWr && regAddr == `DEE_ADDR_BDATA && idle) begin
				byteData_r <= regWdata;
			end
			if (regWr && regAddr == `DEE_ADDR_IRQ_EN) begin
				irqEn_r <= regWdata[2:0];
			end
			// A new event wins over a clear in the same cycle.
			irqStat_r <= (irqStat_r & ~((regWr && regAddr == `DEE_ADDR_IRQ_CLR) ? regWdata[2:0] : 3'h0))
				| {writeRej, readDone, progEn};
			irq <= |(irqStat_r & irqEn_r);
			regRdata <= 8'h00;
			if (regRd) begin
				case (regAddr)
					`DEE_ADDR_CTRL: regRdata <= ctrlValue(readTrig_r, writeTrig_r, writeAllow_r, busy_r, powerOn_r);
					`DEE_ADDR_BADDR: regRdata <= {1'b0, byteAddr_r};
					`DEE_ADDR_BDATA: regRdata <= byteData_r;
					`DEE_ADDR_IRQ_STAT: regRdata <= {5'h00, irqStat_r};
					`DEE_ADDR_IRQ_EN: regRdata <= {5'h00, irqEn_r};
					default: regRdata <= 8'h00;
				endcase
			end
		end
	end

	// Array access runs in normal operation; no special mode is needed.
	dee_array #(.DEPTH(DEPTH), .AW(AW)) uArray (
		.mclk(mclk),
		.rstSync(rstSync_r),
		.powerOn(powerOn_r),
		.addr(byteAddr_r),
		.eraseEn(eraseEn),
		.progEn(progEn),
		.progData(byteData_r),
		.readData(arrayData)
	);

	dee_timer #(.W(TW)) uTimer (
		.mclk(mclk),
		.rstSync(rstSync_r),
		.load(timerLoad),
		.count(timerCount),
		.done(timerDone)
	);
endmodule
`default_nettype wire

// File: dee_defs.vh
`ifndef DEE_DEFS_VH
`define DEE_DEFS_VH
// Register indices on the plain register port.
`define DEE_ADDR_CTRL 3'h0
`define DEE_ADDR_BADDR 3'h1
`define DEE_ADDR_BDATA 3'h2
`define DEE_ADDR_IRQ_STAT 3'h3
`define DEE_ADDR_IRQ_EN 3'h4
`define DEE_ADDR_IRQ_CLR 3'h5
// Control register field positions.
`define DEE_CTRL_READ 7
`define DEE_CTRL_WRITE 6
`define DEE_CTRL_WALLOW 5
`define DEE_CTRL_BUSY 4
`define DEE_CTRL_PWR 3
// Interrupt status bit positions.
`define DEE_IRQ_WDONE 0
`define DEE_IRQ_RDONE 1
`define DEE_IRQ_WREJ 2
// Reset values.
`define DEE_CTRL_RST 8'h00
`define DEE_BADDR_RST 8'h00
`define DEE_BDATA_RST 8'h00
// Erase and program times in ns, and cycle counts at the 8 ns clock.
`define DEE_CLK_NS 8
`define DEE_ERASE_NS 2000
`define DEE_PROG_NS 2000
`define DEE_ERASE_CYC ((`DEE_ERASE_NS + `DEE_CLK_NS - 1) / `DEE_CLK_NS)
`define DEE_PROG_CYC ((`DEE_PROG_NS + `DEE_CLK_NS - 1) / `DEE_CLK_NS)
`endif

// File: dee_array.v
`default_nettype none
// Byte array in flip-flops; erase sets a byte to all ones, program stores a new value.
module dee_array #(
	parameter DEPTH = 128,
	parameter AW = 7
) (
	input wire mclk,
	input wire rstSync,
	input wire powerOn,
	input wire [AW-1:0] addr,
	input wire eraseEn,
	input wire progEn,
	input wire [7:0] progData,
	output wire [7:0] readData
);
	reg [7:0] mem_r [0:DEPTH-1];
	integer i;
	always @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_r[i] <= 8'hFF;
			end
		end else if (powerOn) begin
			if (eraseEn) begin
				mem_r[addr] <= 8'hFF;
			end else if (progEn) begin
				mem_r[addr] <= progData;
			end
		end
	end
	// A powered-down array returns zero rather than stale contents.
	assign readData = powerOn ? mem_r[addr] : 8'h00;
endmodule
`default_nettype wire

// File: dee_timer.v
`default_nettype none
// Down counter that pulses done once after a load of a nonzero count.
module dee_timer #(
	parameter W = 12
) (
	input wire mclk,
	input wire rstSync,
	input wire load,
	input wire [W-1:0] count,
	output reg done
);
	reg [W-1:0] cnt_r;
	reg run_r;
	always @(posedge mclk or negedge rstSync) begin
		if (!rstSync) begin
			cnt_r <= {W{1'b0}};
			run_r <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_r <= count;
				run_r <= 1'b1;
			end else if (run_r) begin
				if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
					run_r <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: dee_ctrl_sva.sv
`default_nettype none
module dee_ctrl_sva (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdata,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire ctrlRd = regRd && regAddr == 3'h0;
	wire ctrlWr = regWr && regAddr == 3'h0;
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00) else $error("stray read data");
	a_addr_msb: assert property ($past(regRd && regAddr == 3'h1) |-> !regRdata[7]) else $error("addr bit7");
	a_ctrl_unused: assert property ($past(ctrlRd) |-> regRdata[2:0] == 3'h0) else $error("ctrl low bits");
	a_busy_pair: assert property ($past(ctrlRd) |-> regRdata[4] == regRdata[6]) else $error("busy pair");
	a_write_start: assert property (ctrlWr && regWdata == 8'h68 ##1 ctrlRd |=> regRdata == 8'h78)
		else $error("write start");
	a_write_refused: assert property (ctrlWr && regWdata == 8'h48 ##1 ctrlRd |=> regRdata == 8'h08)
		else $error("write refused");
	a_read_clear: assert property (ctrlWr && regWdata == 8'h88 ##3 ctrlRd |=> regRdata == 8'h08)
		else $error("read clear");
	a_irq_masked: assert property (regWr && regAddr == 3'h4 && regWdata == 8'h00 |-> ##2 !irq)
		else $error("irq masked");
endmodule
bind dee_ctrl dee_ctrl_sva dee_ctrl_sva_inst (.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
`default_nettype wire

// File: dee_ctrl_test.sv
`default_nettype none
module dee_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] last;
	logic [7:0] vals [2] = '{8'h5A, 8'h0F};
	wire [7:0] regRdata;
	wire irq;
	int mismatches = 0;
	int total_checks = 0;
	// Short erase and program counts keep the run brief.
	dee_ctrl #(.ERASE_CYC(20), .PROG_CYC(20)) dee_ctrl_inst (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
	initial begin
		forever #4 mclk = ~mclk;
	end
	task wrap_up;
		if (mismatches == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Each call drives one cycle; the next call overrides it, so strobes can run back to back.
	task op(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWr <= w;
		regRd <= r;
		regAddr <= a;
		regWdata <= d;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		op(1'b1, 1'b0, a, d);
	endtask
	task idle(input int n);
		repeat (n) op(1'b0, 1'b0, 3'h0, 8'h00);
	endtask
	task fetch(input logic [2:0] a);
		op(1'b0, 1'b1, a, 8'h00);
		idle(1);
		@(negedge mclk);
		last = regRdata;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		fetch(a);
		check(last, e);
	endtask
	task poll;
		repeat (200) begin
			fetch(3'h0);
			if (last[4] === 1'b0) return;
		end
		mismatches++;
	endtask
	task irq_is(input logic e);
		idle(3);
		@(negedge mclk);
		check({7'h00, irq}, {7'h00, e});
	endtask
	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		idle(4);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h00);
		rd(3'h2, 8'h00);
		rd(3'h3, 8'h00);
		wr(3'h4, 8'h07);
		wr(3'h0, 8'h08);
		wr(3'h1, 8'hFF);
		rd(3'h1, 8'h7F);
		wr(3'h2, 8'hA5);
		rd(3'h2, 8'hA5);
		foreach (vals[i]) begin
			wr(3'h1, 8'h7F);
			wr(3'h2, vals[i]);
			wr(3'h0, 8'h68);
			rd(3'h0, 8'h78);
			poll();
			rd(3'h0, 8'h28);
			rd(3'h3, 8'h01);
			wr(3'h5, 8'h01);
			irq_is(1'b0);
			wr(3'h2, 8'h00);
			wr(3'h0, 8'h88);
			idle(2);
			rd(3'h0, 8'h08);
			rd(3'h2, vals[i]);
			irq_is(1'b1);
			wr(3'h5, 8'h07);
		end
		wr(3'h0, 8'h48);
		rd(3'h0, 8'h08);
		wr(3'h0, 8'h60);
		rd(3'h3, 8'h04);
		wr(3'h0, 8'h88);
		idle(2);
		rd(3'h2, 8'h0F);
		wr(3'h0, 8'h80);
		idle(2);
		rd(3'h2, 8'h00);
		wr(3'h4, 8'h00);
		irq_is(1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
